// ===== core/flash_cmd_map.svh
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define OP_WRITE_ENABLE   8'h06
`define OP_VOL_ENABLE     8'h50
`define OP_WRITE_DISABLE  8'h04
`define OP_WR_STAT1       8'h01
`define OP_WR_STAT2       8'h31
`define OP_WR_STAT3       8'h11
`define OP_RD_STAT1       8'h05
`define OP_RD_STAT2       8'h35
`define OP_RD_STAT3       8'h15
`define OP_RD_UPPER       8'hC8
`define OP_WR_UPPER       8'hC5
`define OP_ADDR32_ON      8'hB7
`define OP_ADDR32_OFF     8'hE9
`define OP_READ           8'h03
`define OP_READ_ADDR32    8'h13
`define OP_FAST_READ      8'h0B

// ****************************************************************
// Status fields and reset values
// ****************************************************************
`define SR1_WRITE_MASK    8'hFC
`define SR2_WRITE_MASK    8'h7B
`define SR2_LOCK_MASK     8'h38
`define SR2_PROTECT2_MASK 8'h01
`define SR2_QUAD_POS      1
`define SR3_WRITE_MASK    8'hFE
`define SR3_ADP_POS       1
`define SR1_RESET         8'h00
`define SR2_RESET         8'h00
`define SR3_RESET         8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS         4
`define STATUS_WRITE_TIME_NS  5000000
`define DUMMY_CLOCKS          6'd8

`endif

// ===== core/flash_cmd_pkg.sv
package flash_cmd_pkg;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_OPC   = 7'h02,
    ST_ADDR  = 7'h04,
    ST_DUMMY = 7'h08,
    ST_DIN   = 7'h10,
    ST_DOUT  = 7'h20,
    ST_SKIP  = 7'h40
  } state_e;

  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  sync3;
    logic [5:0]  filt;
    state_e      state;
    logic [7:0]  opcode;
    logic [5:0]  bitCnt;
    logic        addr32;
    logic [31:0] addr;
    logic [15:0] dataIn;
    logic [4:0]  dataCnt;
    logic [7:0]  outSh;
    logic [3:0]  outCnt;
    logic [3:0]  ioOut;
    logic [3:0]  ioOeN;
    logic [7:0]  sr1;
    logic [7:0]  sr2;
    logic [7:0]  sr3;
    logic [7:0]  nv1;
    logic [7:0]  nv2;
    logic [7:0]  nv3;
    logic [7:0]  pend1;
    logic [7:0]  pend2;
    logic [7:0]  pend3;
    logic        write_enable_latch;
    logic        volEn;
    logic        current_address_mode;
    logic [7:0]  ear;
    logic [31:0] wrCnt;
    logic        readStart;
    logic [31:0] readAddr;
  } state_s;

endpackage

// ===== core/flash_cmd_decoder.sv
`timescale 1ns/1ps
`include "flash_cmd_map.svh"

module flash_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_s;

  fifo_s fifoReg;
  fifo_s fifoNext;
  logic  push;
  logic  pop;

  assign inReady  = fifoReg.cnt != (AW+1)'(DEPTH);
  assign outValid = fifoReg.cnt != '0;
  assign outData  = fifoReg.mem[fifoReg.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    fifoNext = fifoReg;
    if (push) begin
      fifoNext.mem[fifoReg.wp] = inData;
      fifoNext.wp = fifoReg.wp + AW'(1);
    end
    if (pop) begin
      fifoNext.rp = fifoReg.rp + AW'(1);
    end
    fifoNext.cnt = fifoReg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Stale bytes of an ended read must never reach the next one.
    if (flush) begin
      fifoNext.wp  = '0;
      fifoNext.rp  = '0;
      fifoNext.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifoReg <= '0;
    end else begin
      fifoReg <= fifoNext;
    end
  end
endmodule // flash_byte_fifo

// Overview of operation
// - 01h/31h/11h write only writable status bits.
// - Lock bits never return from 1 to 0.
// - Non-volatile status write needs latch set.
// - After 50h, write volatile copies, latch stays.
// - Any reset reloads volatile from non-volatile.
// - Non-volatile write holds busy for write time.
// - Write cycle end clears the write latch.
// - Volatile write applies at once, no busy.
// - Status reads answered even while busy.
// - Wide mode ignores quad enable changes.
// - 01h with sixteen bits writes registers 1,2.
// - Upper byte extends address; C8h reads it.
// - C5h loads upper byte only when latched.
// - Upper byte clears on every reset.
// - 32-bit addresses overwrite the upper byte only in 32-bit mode.
// - B7h alone enters 32-bit address mode.
// - E9h alone returns to 24-bit mode.
// - 03h streams bytes MSB first, address increments.
// - 03h/13h ignored while busy.
// - 03h/13h refused in wide mode.
// - 13h always takes a 32-bit address.
// - 0Bh inserts eight dummy clocks.
// - 06h sets latch; 50h enables volatile only.
// - Wide mode moves nibbles, high first.
module flash_cmd_decoder #(
  parameter int StatusWriteCycles =
    (`STATUS_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial link pins
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic [3:0]  ioIn,
  output logic [3:0]       ioOut,
  output logic [3:0]       ioOeN,
  // Mode and reset requests
  input  wire logic        wideCommandMode,
  input  wire logic        engineBusy,
  input  wire logic        deviceResetReq,
  // Status view
  output logic             busy,
  output logic             writeEnableLatch,
  output logic             currentAddressMode,
  output logic             quadEnable,
  output logic [7:0]       upperAddrByte,
  // Array read stream
  output logic             readStart,
  output logic [31:0]      readAddr,
  input  wire logic        fillValid,
  input  wire logic [7:0]  fillData,
  output logic             fillReady
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // nibble shift-in
  function automatic logic [31:0] shiftIn(logic [31:0] v, logic [3:0] b, logic wide);
    return wide ? {v[27:0], b} : {v[30:0], b[0]};
  endfunction

  function automatic logic [7:0] merge(logic [7:0] old, logic [7:0] data,
                                       logic [7:0] mask, logic [7:0] keep);
    return ((old & ~mask) | (data & mask)) | (old & keep);
  endfunction

  function automatic logic isArrayRead(logic [7:0] op);
    return op == `OP_READ || op == `OP_READ_ADDR32 || op == `OP_FAST_READ;
  endfunction

  flash_cmd_pkg::state_s stReg;
  flash_cmd_pkg::state_s stNext;

  logic [5:0]  filtNext;
  logic        sclkRise;
  logic        sclkFall;
  logic        csRise;
  logic        csFall;
  logic [3:0]  inBits;
  logic [5:0]  step;
  logic        wrActive;
  logic        popData;
  logic        fifoValid;
  logic [7:0]  fifoData;
  logic [7:0]  outByte;
  logic [7:0]  byte1;
  logic        twoBytes;
  logic [7:0]  base1;
  logic [7:0]  base2;
  logic [7:0]  base3;
  logic [7:0]  mask2;
  logic [7:0]  keep2;
  logic [7:0]  new1;
  logic [7:0]  new2;
  logic [7:0]  new3;
  logic [31:0] fullAddr;
  logic [31:0] addrShift;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  // A pin counts as changed once the second and third stages agree.
  assign filtNext = (~(stReg.sync2 ^ stReg.sync3) & stReg.sync3)
                  | ((stReg.sync2 ^ stReg.sync3) & stReg.filt);
  assign sclkRise = filtNext[4] & ~stReg.filt[4] & ~filtNext[5];
  assign sclkFall = ~filtNext[4] & stReg.filt[4] & ~filtNext[5];
  assign csRise   = filtNext[5] & ~stReg.filt[5];
  assign csFall   = ~filtNext[5] & stReg.filt[5];
  assign inBits   = wideCommandMode ? filtNext[3:0] : {3'b000, filtNext[0]};
  assign step     = wideCommandMode ? 6'd4 : 6'd1;
  assign wrActive = stReg.wrCnt != 32'h0;
  assign busy     = wrActive | engineBusy;

  // ****************************************************************
  // Status write data
  // ****************************************************************
  // one or two bytes
  assign twoBytes = stReg.dataCnt >= 5'd16;
  assign byte1    = twoBytes ? stReg.dataIn[15:8] : stReg.dataIn[7:0];
  assign base1    = stReg.volEn ? stReg.sr1 : stReg.nv1;
  assign base2    = stReg.volEn ? stReg.sr2 : stReg.nv2;
  assign base3    = stReg.volEn ? stReg.sr3 : stReg.nv3;
  assign mask2 = `SR2_WRITE_MASK & ~(8'(wideCommandMode) << `SR2_QUAD_POS);
  assign keep2 = `SR2_LOCK_MASK | (stReg.volEn ? `SR2_PROTECT2_MASK : 8'h00);

  always_comb begin
    new1 = base1;
    new2 = base2;
    new3 = base3;
    unique case (stReg.opcode)
      `OP_WR_STAT1: begin
        new1 = merge(base1, byte1, `SR1_WRITE_MASK, 8'h00);
        if (twoBytes) begin
          new2 = merge(base2, stReg.dataIn[7:0], mask2, keep2);
        end
      end
      `OP_WR_STAT2: new2 = merge(base2, byte1, mask2, keep2);
      `OP_WR_STAT3: new3 = merge(base3, byte1, `SR3_WRITE_MASK, 8'h00);
      default: ;
    endcase
  end

  // ****************************************************************
  // Read data source
  // ****************************************************************
  // status always readable
  always_comb begin
    unique case (stReg.opcode)
      `OP_RD_STAT1: outByte = {stReg.sr1[7:2], stReg.write_enable_latch, busy};
      `OP_RD_STAT2: outByte = stReg.sr2;
      `OP_RD_STAT3: outByte = {stReg.sr3[7:1], stReg.current_address_mode};
      `OP_RD_UPPER: outByte = stReg.ear;
      // An underrun drives all ones rather than stalling the link.
      default:      outByte = fifoValid ? fifoData : 8'hFF;
    endcase
  end

  assign popData = sclkFall && stReg.state == flash_cmd_pkg::ST_DOUT
                && stReg.outCnt == 4'h0 && isArrayRead(stReg.opcode);
  assign addrShift = shiftIn(stReg.addr, inBits, wideCommandMode);
  assign fullAddr  = stReg.addr32 ? addrShift : {stReg.ear, addrShift[23:0]};

  flash_byte_fifo #(
    .WIDTH (8),
    .DEPTH (32)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (stReg.readStart),
    .inValid  (fillValid),
    .inData   (fillData),
    .inReady  (fillReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (popData)
  );

  // ****************************************************************
  // Command engine
  // ****************************************************************
  always_comb begin
    stNext           = stReg;
    stNext.sync1     = {csN, sclk, ioIn};
    stNext.sync2     = stReg.sync1;
    stNext.sync3     = stReg.sync2;
    stNext.filt      = filtNext;
    stNext.readStart = 1'b0;
    if (wrActive) begin
      stNext.wrCnt = stReg.wrCnt - 32'h1;
      if (stReg.wrCnt == 32'h1) begin
        {stNext.nv1, stNext.nv2, stNext.nv3} = {stReg.pend1, stReg.pend2, stReg.pend3};
        {stNext.sr1, stNext.sr2, stNext.sr3} = {stReg.pend1, stReg.pend2, stReg.pend3};
        stNext.write_enable_latch = 1'b0;
      end
    end
    if (deviceResetReq) begin
      {stNext.sr1, stNext.sr2, stNext.sr3} = {stReg.nv1, stReg.nv2, stReg.nv3};
      stNext.write_enable_latch   = 1'b0;
      stNext.volEn = 1'b0;
      stNext.current_address_mode   = stReg.nv3[`SR3_ADP_POS];
      stNext.ear   = 8'h00;
    end
    if (csFall) begin
      stNext.state   = flash_cmd_pkg::ST_OPC;
      stNext.bitCnt  = 6'd0;
      stNext.dataCnt = 5'd0;
      stNext.outCnt  = 4'h0;
    end else if (csRise) begin
      stNext.state = flash_cmd_pkg::ST_IDLE;
      stNext.ioOeN = 4'hF;
      if (stReg.state == flash_cmd_pkg::ST_DIN) begin
        stNext.volEn = stReg.opcode == `OP_VOL_ENABLE && stReg.dataCnt == 5'd0;
        unique case (stReg.opcode)
          `OP_WRITE_ENABLE: begin
            if (stReg.dataCnt == 5'd0) begin
              stNext.write_enable_latch = 1'b1;
            end
          end
          `OP_WRITE_DISABLE: begin
            if (stReg.dataCnt == 5'd0) begin
              stNext.write_enable_latch = 1'b0;
            end
          end
          `OP_ADDR32_ON: begin
            if (stReg.dataCnt == 5'd0) begin
              stNext.current_address_mode = 1'b1;
            end
          end
          `OP_ADDR32_OFF: begin
            if (stReg.dataCnt == 5'd0) begin
              stNext.current_address_mode = 1'b0;
            end
          end
          `OP_WR_UPPER: begin
            if (stReg.dataCnt >= 5'd8 && stReg.write_enable_latch) begin
              stNext.ear = byte1;
            end
          end
          `OP_WR_STAT1, `OP_WR_STAT2, `OP_WR_STAT3: begin
            if (stReg.dataCnt >= 5'd8) begin
              if (stReg.volEn) begin
                {stNext.sr1, stNext.sr2, stNext.sr3} = {new1, new2, new3};
              end else if (stReg.write_enable_latch && !busy) begin
                {stNext.pend1, stNext.pend2, stNext.pend3} = {new1, new2, new3};
                stNext.wrCnt = 32'(StatusWriteCycles);
              end
            end
          end
          default: ;
        endcase
      end else begin
        stNext.volEn = 1'b0;
      end
    end else if (sclkRise) begin
      unique case (stReg.state)
        flash_cmd_pkg::ST_OPC: begin
          stNext.opcode = 8'(shiftIn({24'h0, stReg.opcode}, inBits, wideCommandMode));
          stNext.bitCnt = stReg.bitCnt + step;
          if (stNext.bitCnt == 6'd8) begin
            stNext.bitCnt = 6'd0;
            unique case (stNext.opcode)
              `OP_RD_STAT1, `OP_RD_STAT2, `OP_RD_STAT3, `OP_RD_UPPER:
                stNext.state = flash_cmd_pkg::ST_DOUT;
              `OP_READ, `OP_READ_ADDR32: begin
                stNext.state = (wideCommandMode || busy) ? flash_cmd_pkg::ST_SKIP
                                                         : flash_cmd_pkg::ST_ADDR;
                stNext.addr32 = stNext.opcode == `OP_READ_ADDR32 || stReg.current_address_mode;
              end
              `OP_FAST_READ: begin
                stNext.state  = wideCommandMode ? flash_cmd_pkg::ST_SKIP
                                                : flash_cmd_pkg::ST_ADDR;
                stNext.addr32 = stReg.current_address_mode;
              end
              `OP_WRITE_ENABLE, `OP_VOL_ENABLE, `OP_WRITE_DISABLE, `OP_ADDR32_ON,
              `OP_ADDR32_OFF, `OP_WR_UPPER, `OP_WR_STAT1, `OP_WR_STAT2, `OP_WR_STAT3:
                stNext.state = flash_cmd_pkg::ST_DIN;
              default: stNext.state = flash_cmd_pkg::ST_SKIP;
            endcase
          end
        end
        flash_cmd_pkg::ST_ADDR: begin
          stNext.addr   = addrShift;
          stNext.bitCnt = stReg.bitCnt + step;
          if (stNext.bitCnt == (stReg.addr32 ? 6'd32 : 6'd24)) begin
            stNext.bitCnt    = 6'd0;
            stNext.readAddr  = fullAddr;
            stNext.readStart = 1'b1;
            if (stReg.addr32 && stReg.current_address_mode) begin
              stNext.ear = stNext.addr[31:24];
            end
            stNext.state = (stReg.opcode == `OP_FAST_READ) ? flash_cmd_pkg::ST_DUMMY
                                                           : flash_cmd_pkg::ST_DOUT;
          end
        end
        flash_cmd_pkg::ST_DUMMY: begin
          stNext.bitCnt = stReg.bitCnt + 6'd1;
          if (stNext.bitCnt == `DUMMY_CLOCKS) begin
            stNext.state = flash_cmd_pkg::ST_DOUT;
          end
        end
        flash_cmd_pkg::ST_DIN: begin
          if (stReg.dataCnt < 5'd16) begin
            stNext.dataIn  = 16'(shiftIn({16'h0, stReg.dataIn}, inBits, wideCommandMode));
            stNext.dataCnt = stReg.dataCnt + step[4:0];
          end
        end
        default: ;
      endcase
    end else if (sclkFall && stReg.state == flash_cmd_pkg::ST_DOUT) begin
      stNext.ioOeN = wideCommandMode ? 4'h0 : 4'hD;
      if (stReg.outCnt == 4'h0) begin
        stNext.ioOut  = wideCommandMode ? outByte[7:4] : {2'b00, outByte[7], 1'b0};
        stNext.outSh  = wideCommandMode ? {outByte[3:0], 4'h0} : {outByte[6:0], 1'b0};
        stNext.outCnt = 4'd8 - step[3:0];
        if (popData) begin
          stNext.readAddr = stReg.readAddr + 32'h1;
        end
      end else begin
        stNext.ioOut  = wideCommandMode ? stReg.outSh[7:4] : {2'b00, stReg.outSh[7], 1'b0};
        stNext.outSh  = wideCommandMode ? {stReg.outSh[3:0], 4'h0} : {stReg.outSh[6:0], 1'b0};
        stNext.outCnt = stReg.outCnt - step[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stReg       <= '0;
      stReg.sync1 <= 6'h20;
      stReg.sync2 <= 6'h20;
      stReg.sync3 <= 6'h20;
      stReg.filt  <= 6'h20;
      stReg.state <= flash_cmd_pkg::ST_IDLE;
      stReg.ioOeN <= 4'hF;
      stReg.sr1   <= `SR1_RESET;
      stReg.sr2   <= `SR2_RESET;
      stReg.sr3   <= `SR3_RESET;
      stReg.nv1   <= `SR1_RESET;
      stReg.nv2   <= `SR2_RESET;
      stReg.nv3   <= `SR3_RESET;
      stReg.current_address_mode   <= 1'((`SR3_RESET >> `SR3_ADP_POS) & 8'h01);
    end else begin
      stReg <= stNext;
    end
  end

  assign ioOut              = stReg.ioOut;
  assign ioOeN              = stReg.ioOeN;
  assign writeEnableLatch   = stReg.write_enable_latch;
  assign currentAddressMode = stReg.current_address_mode;
  assign quadEnable         = stReg.sr2[`SR2_QUAD_POS];
  assign upperAddrByte      = stReg.ear;
  assign readStart          = stReg.readStart;
  assign readAddr           = stReg.readAddr;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_lock_bits_hold: assert property (
    ##1 ((stReg.nv2 & $past(stReg.nv2) & `SR2_LOCK_MASK) == ($past(stReg.nv2) & `SR2_LOCK_MASK)))
    else $error("lock bit cleared");
  a_nv_needs_latch: assert property (
    $rose(wrActive) |-> $past(stReg.write_enable_latch) && !$past(stReg.volEn))
    else $error("write cycle without latch");
  a_write_busy_len: assert property (
    $rose(wrActive) |-> busy [*8])
    else $error("busy ended early");
  a_latch_clears: assert property (
    $fell(wrActive) && !$past(csRise) |-> !stReg.write_enable_latch)
    else $error("latch kept after write");
  a_upper_reset: assert property (
    deviceResetReq && !csRise && !sclkRise |=> stReg.ear == 8'h00)
    else $error("upper byte not cleared");
  a_busy_read_skip: assert property (
    stReg.state == flash_cmd_pkg::ST_ADDR && $past(stReg.state) == flash_cmd_pkg::ST_OPC
      && stReg.opcode != `OP_FAST_READ |-> !$past(busy))
    else $error("read taken while busy");
  a_wide_read_skip: assert property (
    stReg.state == flash_cmd_pkg::ST_ADDR && $past(stReg.state) == flash_cmd_pkg::ST_OPC
      |-> !$past(wideCommandMode))
    else $error("read taken in wide mode");
  a_addr_upper: assert property (
    stReg.readStart && ($past(stReg.current_address_mode) || !stReg.addr32)
      |-> stReg.readAddr[31:24] == stReg.ear)
    else $error("upper byte mismatch");

  c_nv_write: cover property ($rose(wrActive));
  c_read_start: cover property (stReg.readStart && stReg.opcode == `OP_FAST_READ);
  c_vol_write: cover property ($changed(stReg.sr2) && !wrActive && !deviceResetReq);

endmodule // flash_cmd_decoder

// ===== dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic       clk,
  // Serial link
  output logic            csN,
  output logic            sclk,
  output logic [3:0]      ioIn,
  input  wire logic [3:0] ioOut
);
  logic [63:0] rx;

  initial begin
    csN  = 1'h1;
    sclk = 1'h0;
    ioIn = 4'h0;
    rx   = 64'h0;
  end

  // ****************
  // Frame driver
  // ****************
  // A half period of six clocks gives the 48 ns link clock; it stands still between frames.
  task automatic frame(input logic [63:0] tx, input int n, input int w);
    @(negedge clk);
    csN = 1'h0;
    for (int i = n - w; i >= 0; i -= w) begin
      ioIn = (w == 4) ? tx[i +: 4] : {3'h0, tx[i]};
      repeat (6) @(negedge clk);
      sclk = 1'h1;
      rx   = {rx[62:0], ioOut[1]};
      repeat (6) @(negedge clk);
      sclk = 1'h0;
    end
    repeat (6) @(negedge clk);
    csN = 1'h1;
    // A released line must not keep showing its last level.
    ioIn = ~ioIn;
    repeat (12) @(negedge clk);
  endtask
endmodule // spi_host_model

// ===== dv/serial_flash_status_addr_read_cmds_tb_top.sv
`timescale 1ns/1ps
module serial_flash_status_addr_read_cmds_tb_top;
  logic        clk, rst_n, csN, sclk, wideCommandMode, engineBusy, deviceResetReq;
  logic        busy, writeEnableLatch, currentAddressMode, quadEnable, readStart;
  logic [3:0]  ioIn, ioOut, ioOeN;
  logic [7:0]  upperAddrByte;
  logic [31:0] readAddr, startAddr;
  logic        fillValid = 1'h0, fillReady, armed = 1'h0, sawFull = 1'h0, took = 1'h0;
  logic [7:0]  fillData = 8'h0;
  int          nStart = 0, n_mismatch = 0, checks = 0;

  flash_cmd_decoder #(.StatusWriteCycles(400)) DUT (.clk, .rst_n, .csN, .sclk, .ioIn, .ioOut,
    .ioOeN, .wideCommandMode, .engineBusy, .deviceResetReq, .busy, .writeEnableLatch,
    .currentAddressMode, .quadEnable, .upperAddrByte, .readStart, .readAddr, .fillValid,
    .fillData, .fillReady);
  spi_host_model host (.clk, .csN, .sclk, .ioIn, .ioOut);

  // ****************
  // Array source
  // ****************
  // Bytes follow the start address; the source stalls every other cycle.
  // The handshake is judged at the rising edge, where the FIFO itself takes it.
  always @(posedge clk) took <= fillValid && fillReady;
  always @(negedge clk) begin
    if (readStart === 1'h1) begin
      fillData  <= readAddr[7:0];
      startAddr <= readAddr;
      nStart    <= nStart + 1;
    end else if (took) fillData <= fillData + 8'h1;
    armed     <= (readStart === 1'h1) || (armed && !csN);
    fillValid <= armed && !took;
    if (fillReady === 1'h0) sawFull <= 1'h1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    host.frame({48'h0, op, 8'h0}, 16, 1);
    check(host.rx[7:0], exp);
    check(ioOeN, 4'hF);
  endtask
  task automatic idle();
    for (int i = 0; i < 3000 && busy !== 1'h0; i++) @(negedge clk);
    check(busy, 1'h0);
  endtask
  task automatic devRst();
    deviceResetReq = 1'h1;
    @(negedge clk);
    deviceResetReq = 1'h0;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_legacy();
    host.frame(64'h01FC40, 24, 1);
    rd(8'h05, 8'h00);
    host.frame(64'h06, 8, 1);
    host.frame(64'h01FC40, 24, 1);
    check(busy, 1'h1);
    rd(8'h05, 8'h03);
    idle();
    check({busy, writeEnableLatch}, 2'h0);
    rd(8'h05, 8'hFC);
    rd(8'h35, 8'h40);
    host.frame(64'h06, 8, 1);
    host.frame(64'h0100, 16, 1);
    idle();
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h40);
    $display("legacy status write test done");
  endtask
  task automatic t_status();
    host.frame(64'h06, 8, 1);
    check(writeEnableLatch, 1'h1);
    host.frame(64'h31FF, 16, 1);
    idle();
    rd(8'h35, 8'h7B);
    host.frame(64'h50, 8, 1);
    host.frame(64'h3100, 16, 1);
    check({busy, writeEnableLatch, quadEnable}, 3'h0);
    rd(8'h35, 8'h39);
    devRst();
    rd(8'h35, 8'h7B);
    $display("volatile status test done");
  endtask
  task automatic t_upper();
    host.frame(64'hC512, 16, 1);
    check(upperAddrByte, 8'h00);
    host.frame(64'h06, 8, 1);
    host.frame(64'hC512, 16, 1);
    rd(8'hC8, 8'h12);
    devRst();
    check(upperAddrByte, 8'h00);
    $display("upper byte test done");
  endtask
  task automatic t_read();
    host.frame(64'hB700, 16, 1);
    check(currentAddressMode, 1'h0);
    host.frame(64'hB7, 8, 1);
    check(currentAddressMode, 1'h1);
    host.frame(64'h03A50000100000, 56, 1);
    check({upperAddrByte, startAddr, host.rx[15:0]}, 56'hA5A50000101011);
    host.frame(64'hE9, 8, 1);
    check(currentAddressMode, 1'h0);
    host.frame(64'h0B0000F0000000, 56, 1);
    check({startAddr, host.rx[15:0]}, 48'hA50000F0F0F1);
    host.frame(64'h13010203040000, 56, 1);
    check({startAddr, host.rx[15:0]}, 48'h010203040405);
    check(sawFull, 1'h1);
    $display("array read test done");
  endtask
  task automatic t_refuse();
    engineBusy = 1'h1;
    host.frame(64'h03000000, 32, 1);
    engineBusy = 1'h0;
    check(nStart, 3);
    wideCommandMode = 1'h1;
    host.frame(64'h03000000, 32, 4);
    check(nStart, 3);
    host.frame(64'h50, 8, 4);
    host.frame(64'h3100, 16, 4);
    check(quadEnable, 1'h1);
    wideCommandMode = 1'h0;
    $display("refusal test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'h0;
    wideCommandMode = 1'h0;
    engineBusy = 1'h0;
    deviceResetReq = 1'h0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (8) @(negedge clk);
    t_legacy();
    t_status();
    t_upper();
    t_read();
    t_refuse();
    end_of_test();
  end
  // The tests need about 9k cycles; the limit leaves ample margin.
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
endmodule // serial_flash_status_addr_read_cmds_tb_top
